/* File: core/cdm_datapath.sv */
// cdm_datapath: program counter, stack, index pointer, RAM and ALU
`timescale 1ns/1ns
module cdm_datapath (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // instruction command, one per cycle
    input  wire cdm_pkg::cdm_cmd_t cmd,
    // table memory data for the current index pointer
    input  wire logic [7:0]       table_data,
    // sequencing state
    output logic [10:0]           program_counter,
    output logic [2:0]            stack_ptr,
    // arithmetic state
    output logic [3:0]            accumulator,
    output logic                  carry_flag,
    output logic                  zero_flag,
    // addressing and read results
    output logic [11:0]           index_pointer,
    output logic [3:0]            read_data,
    output logic [7:0]            table_out,
    output logic                  done
);
    import cdm_pkg::*;

    cdm_state_t st;
    cdm_state_t next_st;

    logic [8:0] eff_addr;
    logic [7:0] op_slot;
    logic [7:0] wr_slot;
    logic [3:0] operand;
    logic [3:0] work_val;
    logic [3:0] alu_b;
    logic [3:0] alu_res;
    logic       alu_cout;
    logic       wr_en;
    logic [7:0] wr_at;
    logic [3:0] wr_val;
    logic [2:0] pop_at;

    // map a 9-bit RAM address onto the 96 cells; bit 7 flags presence
    function automatic logic [7:0] ram_slot(input logic [8:0] a);
        logic [7:0] s;
        s = 8'h00;
        if (a < RAM_HOLE_LO) begin
            s = {1'b1, a[6:0]};
        end else if (a > RAM_HOLE_HI && a <= RAM_TOP) begin
            s = {1'b1, a[6:0] - HOLE_SIZE};
        end
        return s;
    endfunction

    // every output is a state field, so it leaves a flip-flop directly
    assign program_counter = st.program_counter;
    assign stack_ptr       = st.stack_ptr;
    assign accumulator     = st.accumulator;
    assign carry_flag      = st.carry_flag;
    assign zero_flag       = st.zero_flag;
    assign index_pointer   = {st.index_pointer_high,
                              st.index_pointer_low};
    assign read_data       = st.read_data;
    assign table_out       = st.table_out;
    assign done            = st.done;

    // operand address: instruction field, index pointer or work register
    always_comb begin
        eff_addr = {2'b00, cmd.addr};
        if (cmd.amode == am_index) begin
            eff_addr = index_pointer[8:0];
        end else if (cmd.amode == am_work) begin
            eff_addr = WR_BASE | {5'h00, cmd.wreg};
        end
    end

    // absent cells read as zero rather than aliasing
    assign op_slot  = ram_slot(eff_addr);
    assign wr_slot  = ram_slot(WR_BASE | {5'h00, cmd.wreg});
    assign operand  = op_slot[7] ? st.ram[op_slot[6:0]] : 4'h0;
    assign work_val = st.ram[wr_slot[6:0]];
    // decimal adjusts always work on the accumulator, never the immediate
    assign alu_b    = (cmd.use_imm && cmd.op != decimal_adjust_add_op
                       && cmd.op != decimal_adjust_sub_op)
                    ? cmd.imm : st.accumulator;
    assign pop_at   = st.stack_ptr - 3'h1;

    cdm_alu u_alu (
        .op   (cmd.op),
        .a    (operand),
        .b    (alu_b),
        .cin  (st.carry_flag),
        .res  (alu_res),
        .cout (alu_cout)
    );

    // next state; a single RAM write port serves every store
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        wr_en        = 1'b0;
        wr_at        = op_slot;
        wr_val       = st.accumulator;
        if (cmd.valid) begin
            next_st.done            = 1'b1;
            next_st.read_data       = operand;
            next_st.program_counter = st.program_counter + PC_STEP;
            case (cmd.op)
                op_ldi: next_st.accumulator = cmd.imm;
                op_ldr: next_st.accumulator = operand;
                op_str: wr_en = 1'b1;
                op_mwr: begin
                    wr_en  = 1'b1;
                    wr_val = work_val;
                end
                op_mrw: begin
                    wr_en  = 1'b1;
                    wr_at  = wr_slot;
                    wr_val = operand;
                end
                op_add, op_adc, op_sub, op_sbc, op_inc, op_dec,
                op_and, op_eor, op_or, op_sr0, op_sr1, op_sl0,
                op_sl1, decimal_adjust_add_op,
                decimal_adjust_sub_op: begin
                    next_st.accumulator = alu_res;
                    next_st.carry_flag  = alu_cout;
                    wr_en  = cmd.store;
                    wr_val = alu_res;
                end
                load_index_low_op: begin
                    next_st.index_pointer_low = operand;
                end
                load_index_high_op: begin
                    next_st.index_pointer_high = {st.accumulator,
                                                  operand};
                end
                op_tbl_byte: next_st.table_out = table_data;
                op_tbl_nib: begin
                    next_st.table_out = {4'h0, cmd.nib_hi ?
                        table_data[7:4] : table_data[3:0]};
                end
                op_jmp: next_st.program_counter = cmd.target;
                // return address is the instruction after the call
                op_call: begin
                    next_st.stack[st.stack_ptr] =
                        st.program_counter + PC_STEP;
                    next_st.stack_ptr = st.stack_ptr + 3'h1;
                    next_st.program_counter = cmd.target;
                end
                // an interrupt resumes the instruction it displaced
                op_int: begin
                    next_st.stack[st.stack_ptr] =
                        st.program_counter;
                    next_st.stack_ptr = st.stack_ptr + 3'h1;
                    next_st.program_counter = vec_addr(cmd.vec);
                end
                // no underflow flag: an empty stack simply wraps
                op_ret: begin
                    next_st.stack_ptr       = pop_at;
                    next_st.program_counter = st.stack[pop_at];
                end
                op_jb: begin
                    if (st.accumulator[cmd.bsel]) begin
                        next_st.program_counter = cmd.target;
                    end
                end
                op_jc: begin
                    if (st.carry_flag) begin
                        next_st.program_counter = cmd.target;
                    end
                end
                op_jnc: begin
                    if (!st.carry_flag) begin
                        next_st.program_counter = cmd.target;
                    end
                end
                op_jz: begin
                    if (st.zero_flag) begin
                        next_st.program_counter = cmd.target;
                    end
                end
                op_jnz: begin
                    if (!st.zero_flag) begin
                        next_st.program_counter = cmd.target;
                    end
                end
                default: next_st.read_data = operand;
            endcase
            // writes into the hole are dropped
            if (wr_en && wr_at[7]) begin
                next_st.ram[wr_at[6:0]] = wr_val;
            end
            next_st.zero_flag = (next_st.accumulator == 4'h0);
        end
    end

    // state register; RAM contents are cleared for determinism
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st                 <= '0;
            st.program_counter <= VEC_RESET;
            st.accumulator     <= ACC_RESET;
            st.carry_flag      <= CARRY_RESET;
            st.zero_flag       <= 1'b1;
            st.stack_ptr       <= SP_RESET;
        end else begin
            st <= next_st;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic is_push;
    logic is_ret;
    logic hole_dir;
    assign is_push  = cmd.valid && (cmd.op == op_call || cmd.op == op_int);
    assign is_ret   = cmd.valid && cmd.op == op_ret;
    assign hole_dir = cmd.amode == am_direct
                   && {2'b00, cmd.addr} >= RAM_HOLE_LO
                   && {2'b00, cmd.addr} <= RAM_HOLE_HI;

    sequence call_seq;
        cmd.valid && cmd.op == op_call;
    endsequence

    sequence call_ret_seq;
        call_seq ##1 is_ret;
    endsequence

    vector_entry_a: assert property (
        cmd.valid && cmd.op == op_int
        |=> program_counter == vec_addr($past(cmd.vec)))
        else $error("interrupt entry address wrong");

    table_byte_a: assert property (
        cmd.valid && cmd.op == op_tbl_byte
        |=> table_out == $past(table_data) && done)
        else $error("table byte not captured");

    index_low_a: assert property (
        cmd.valid && cmd.op == load_index_low_op
        |=> index_pointer[3:0] == read_data
            && index_pointer[11:4] == $past(index_pointer[11:4]))
        else $error("index low load wrong");

    index_high_a: assert property (
        cmd.valid && cmd.op == load_index_high_op
        |=> index_pointer[11:4] == {$past(accumulator), read_data})
        else $error("index high load wrong");

    call_return_a: assert property (
        call_ret_seq
        |=> program_counter == $past(program_counter, 2) + PC_STEP
            && stack_ptr == $past(stack_ptr, 2))
        else $error("call then return did not resume");

    push_wrap_a: assert property (
        is_push && stack_ptr == 3'h7
        |=> stack_ptr == 3'h0)
        else $error("stack push did not wrap");

    pop_wrap_a: assert property (
        is_ret && stack_ptr == 3'h0
        |=> stack_ptr == 3'h7
            && program_counter == $past(st.stack[7]))
        else $error("empty stack pop did not wrap");

    hole_read_a: assert property (
        cmd.valid && cmd.op == op_ldr && hole_dir
        |=> read_data == 4'h0 && accumulator == 4'h0 && zero_flag)
        else $error("absent RAM did not read zero");

    decimal_add_a: assert property (
        cmd.valid && cmd.op == decimal_adjust_add_op
        && !carry_flag && accumulator > DEC_MAX
        |=> carry_flag
            && accumulator == $past(accumulator) + ADD_FIX)
        else $error("decimal adjust after add wrong");

    decimal_sub_a: assert property (
        cmd.valid && cmd.op == decimal_adjust_sub_op
        && !carry_flag && accumulator >= SUB_MIN
        |=> !carry_flag
            && accumulator == $past(accumulator) + SUB_FIX)
        else $error("decimal adjust after subtract wrong");

    sub_borrow_a: assert property (
        cmd.valid && cmd.op == op_sub
        |=> carry_flag
            == (read_data >= $past(cmd.use_imm ? cmd.imm : accumulator)))
        else $error("subtract carry not inverted borrow");

    counter_step_a: assert property (
        cmd.valid && cmd.op == op_nop
        |=> program_counter == $past(program_counter) + PC_STEP)
        else $error("program counter did not step");

    // stack, strobe and result checks
    push_over_a: assert property (
        is_push && stack_ptr == 3'h0
        |=> st.stack[0] == $past(program_counter)
                           + {10'h000, $past(cmd.op == op_call)})
        else $error("push did not overwrite entry 0");

    ret_pop_a: assert property (
        is_ret
        |=> stack_ptr == $past(stack_ptr) - 3'h1
            && program_counter == $past(st.stack[stack_ptr - 3'h1]))
        else $error("return did not pop last entry");

    done_pulse_a: assert property (
        cmd.valid
        |=> done)
        else $error("done missing after command");

    done_drop_a: assert property (
        !cmd.valid
        |=> !done)
        else $error("done without command");

    zero_flag_a: assert property (
        cmd.valid
        |=> zero_flag == (accumulator == 4'h0))
        else $error("zero flag does not follow accumulator");

    table_nib_a: assert property (
        cmd.valid && cmd.op == op_tbl_nib
        |=> table_out[7:4] == 4'h0
            && table_out[3:0] == ($past(cmd.nib_hi)
                ? $past(table_data[7:4]) : $past(table_data[3:0])))
        else $error("table nibble not captured");

    index_far_a: assert property (
        cmd.valid && cmd.amode == am_index && index_pointer[8:7] != 2'b00
        |=> read_data == 4'h0)
        else $error("index read past RAM not zero");

    carry_keep_a: assert property (
        cmd.valid && (cmd.op == op_and || cmd.op == op_eor
                      || cmd.op == op_or)
        |=> carry_flag == $past(carry_flag))
        else $error("logic operation changed carry");
endmodule

/* File: core/cdm_pkg.sv */
// cdm_pkg: constants, command and state carriers of the core datapath
// Overview of operation
// - fixed reset and interrupt entry addresses
// - table reads use index pointer, byte or nibble
// - 12-bit index pointer addresses RAM and table
// - load-index-low copies a RAM nibble
// - load-index-high takes RAM and accumulator nibbles
// - eight 11-bit stack entries, no overflow flag
// - call or interrupt pushes, return pops last
// - push on full stack overwrites entry 0
// - pop on empty stack loads entry 7
// - 96 RAM nibbles, 50h to 6Fh absent
// - direct addressing spans 00h to 7Fh
// - index addressing spans 000h to 1FFh
// - 70h to 7Fh double as working registers
// - add, subtract, logic, shifts, conditional branches
// - decimal adjust after addition table
// - decimal adjust after subtraction table
// - subtraction carry set means no borrow
// - 11-bit program counter reloaded on return
package cdm_pkg;
    // widths and depths
    localparam int PC_W        = 11;
    localparam int STACK_DEPTH = 8;
    localparam int RAM_WORDS   = 96;
    // entry points
    localparam logic [10:0] VEC_RESET    = 11'h000;
    localparam logic [10:0] VEC_PIN      = 11'h010;
    localparam logic [10:0] VEC_PORT     = 11'h014;
    localparam logic [10:0] VEC_TIMER    = 11'h018;
    localparam logic [10:0] VEC_PRESCALE = 11'h01c;
    localparam logic [10:0] VEC_KEYSCAN  = 11'h024;
    localparam logic [10:0] VEC_EXTRA    = 11'h028;
    localparam logic [10:0] PC_STEP      = 11'h001;
    // data RAM map
    localparam logic [8:0] RAM_HOLE_LO = 9'h050;
    localparam logic [8:0] RAM_HOLE_HI = 9'h06f;
    localparam logic [8:0] RAM_TOP     = 9'h07f;
    localparam logic [8:0] WR_BASE     = 9'h070;
    localparam logic [6:0] HOLE_SIZE   = 7'h20;
    // decimal adjust limits
    localparam logic [3:0] DEC_MAX    = 4'h9;
    localparam logic [3:0] ADD_FIX    = 4'h6;
    localparam logic [3:0] SUB_FIX    = 4'ha;
    localparam logic [3:0] ADD_CY_MAX = 4'h3;
    localparam logic [3:0] SUB_MIN    = 4'h6;
    // reset values
    localparam logic [3:0] ACC_RESET   = 4'h0;
    localparam logic       CARRY_RESET = 1'b0;
    localparam logic [2:0] SP_RESET    = 3'h0;

    typedef enum logic [5:0] {
        op_nop, op_ldi, op_ldr, op_str, op_mwr, op_mrw,
        op_add, op_adc, op_sub, op_sbc, op_inc, op_dec,
        op_and, op_eor, op_or, op_sr0, op_sr1, op_sl0, op_sl1,
        decimal_adjust_add_op, decimal_adjust_sub_op,
        load_index_low_op, load_index_high_op,
        op_tbl_byte, op_tbl_nib, op_jmp, op_call, op_int,
        op_ret, op_jb, op_jc, op_jnc, op_jz, op_jnz
    } cdm_op_t;

    typedef enum logic [1:0] {am_direct, am_index, am_work} cdm_amode_t;

    typedef enum logic [2:0] {
        vec_reset, vec_pin, vec_port, vec_timer,
        vec_prescale, vec_keyscan, vec_extra
    } cdm_vec_t;

    typedef struct packed {
        logic       valid;
        cdm_op_t    op;
        cdm_amode_t amode;
        logic [6:0] addr;
        logic [3:0] wreg;
        logic [3:0] imm;
        logic       use_imm;
        logic       store;
        logic [10:0] target;
        cdm_vec_t   vec;
        logic [1:0] bsel;
        logic       nib_hi;
    } cdm_cmd_t;

    typedef struct packed {
        logic [RAM_WORDS-1:0][3:0]        ram;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [2:0]      stack_ptr;
        logic [PC_W-1:0] program_counter;
        logic [3:0]      accumulator;
        logic            carry_flag;
        logic            zero_flag;
        logic [7:0]      index_pointer_high;
        logic [3:0]      index_pointer_low;
        logic [3:0]      read_data;
        logic [7:0]      table_out;
        logic            done;
    } cdm_state_t;

    // entry address of each interrupt source
    function automatic logic [10:0] vec_addr(input cdm_vec_t v);
        logic [10:0] a;
        a = VEC_RESET;
        case (v)
            vec_pin:      a = VEC_PIN;
            vec_port:     a = VEC_PORT;
            vec_timer:    a = VEC_TIMER;
            vec_prescale: a = VEC_PRESCALE;
            vec_keyscan:  a = VEC_KEYSCAN;
            vec_extra:    a = VEC_EXTRA;
            default:      a = VEC_RESET;
        endcase
        return a;
    endfunction
endpackage

/* File: core/cdm_alu.sv */
// cdm_alu: nibble arithmetic, logic, shift and decimal adjust
`timescale 1ns/1ns
module cdm_alu (
    // operation
    input  wire cdm_pkg::cdm_op_t op,
    // operands: a from memory, b accumulator or immediate
    input  wire logic [3:0]       a,
    input  wire logic [3:0]       b,
    input  wire logic             cin,
    // result
    output logic [3:0]            res,
    output logic                  cout
);
    import cdm_pkg::*;

    logic [4:0] sum;

    // one case per operation class
    always_comb begin
        sum  = 5'h00;
        res  = a;
        cout = cin;
        case (op)
            op_add, op_adc: begin
                sum  = {1'b0, a} + {1'b0, b} + {4'h0, cin & (op == op_adc)};
                res  = sum[3:0];
                cout = sum[4];
            end
            // carry out of a + ~b + 1 is the inverted borrow
            op_sub, op_sbc: begin
                sum  = {1'b0, a} + {1'b0, ~b}
                     + {4'h0, (op == op_sub) | cin};
                res  = sum[3:0];
                cout = sum[4];
            end
            op_inc: begin
                sum  = {1'b0, a} + 5'h01;
                res  = sum[3:0];
                cout = sum[4];
            end
            op_dec: begin
                sum  = {1'b0, a} + 5'h0f;
                res  = sum[3:0];
                cout = sum[4];
            end
            op_and: res = a & b;
            op_eor: res = a ^ b;
            op_or:  res = a | b;
            op_sr0: res = {1'b0, a[3:1]};
            op_sr1: res = {1'b1, a[3:1]};
            op_sl0: res = {a[2:0], 1'b0};
            op_sl1: res = {a[2:0], 1'b1};
            // combinations outside the table leave the value alone
            decimal_adjust_add_op: begin
                res = b;
                if (!cin && b > DEC_MAX) begin
                    res  = b + ADD_FIX;
                    cout = 1'b1;
                end else if (cin && b <= ADD_CY_MAX) begin
                    res = b + ADD_FIX;
                end
            end
            decimal_adjust_sub_op: begin
                res = b;
                if (!cin && b >= SUB_MIN) begin
                    res = b + SUB_FIX;
                end
            end
            default: res = a;
        endcase
    end
endmodule

/* File: verif/cdm_datapath_bench.sv */
// cdm_datapath_bench: self-checking bench for the core datapath
`timescale 1ns/1ns
module cdm_datapath_bench;
    import cdm_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    cdm_cmd_t    cmd = '0;
    logic [7:0]  table_data;
    logic [10:0] pc;
    logic [2:0]  sp;
    logic [3:0]  acc;
    logic        cy;
    logic        zf;
    logic [11:0] ip;
    logic [3:0]  rd;
    logic [7:0]  tout;
    logic        done;
    int          err_count = 0;
    int          samples_checked = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    // table contents depend on every pointer bit, so a wrong address shows
    assign table_data = ip[11:4] ^ {ip[3:0], 4'h9};

    cdm_datapath uut (
        .clk             (clk),
        .reset           (reset),
        .cmd             (cmd),
        .table_data      (table_data),
        .program_counter (pc),
        .stack_ptr       (sp),
        .accumulator     (acc),
        .carry_flag      (cy),
        .zero_flag       (zf),
        .index_pointer   (ip),
        .read_data       (rd),
        .table_out       (tout),
        .done            (done)
    );

    // compare any result up to 12 bits wide
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // direct-mode command with immediate as b operand
    function automatic cdm_cmd_t mk(input cdm_op_t op, input logic [6:0] a,
                                    input logic [3:0] i);
        cdm_cmd_t c;
        c = '0;
        c.op = op;
        c.addr = a;
        c.imm = i;
        c.use_imm = 1'b1;
        return c;
    endfunction

    // one command, then an idle cycle; done must pulse after the edge
    task automatic issue(input cdm_cmd_t c);
        @(posedge clk);
        #1;
        c.valid = 1'b1;
        cmd = c;
        @(posedge clk);
        #1;
        cmd.valid = 1'b0;
        chk(done, 12'h1);
    endtask

    task automatic poke(input logic [6:0] a, input logic [3:0] v);
        issue(mk(op_ldi, 7'h00, v));
        issue(mk(op_str, a, 4'h0));
    endtask

    task automatic t_reset;
        chk(pc, 12'h000);
        chk(sp, 12'h0);
        chk({cy, zf, acc}, 12'h010);
        chk(ip, 12'h000);
        chk({tout, rd}, 12'h000);
        chk(done, 12'h0);
        $display("test reset done");
    endtask

    task automatic t_vectors;
        logic [10:0] vt [7];
        cdm_cmd_t    c;
        vt = '{11'h000, 11'h010, 11'h014, 11'h018, 11'h01c, 11'h024, 11'h028};
        c = mk(op_jmp, 7'h00, 4'h0);
        c.target = 11'h100;
        issue(c);
        chk(pc, 12'h100);
        for (int v = 0; v < 7; v++) begin
            c.op = op_int;
            c.vec = cdm_vec_t'(v);
            issue(c);
            chk(pc, {1'b0, vt[v]});
            chk(sp, 12'(v + 1));
        end
        // unwind: each return gives back the pc seen at that entry
        for (int v = 6; v >= 0; v--) begin
            issue(mk(op_ret, 7'h00, 4'h0));
            chk(pc, (v == 0) ? 12'h100 : {1'b0, vt[(v + 6) % 7]});
            chk(sp, 12'(v));
        end
        $display("test vectors done");
    endtask

    task automatic t_stack;
        cdm_cmd_t c;
        c = mk(op_jmp, 7'h00, 4'h0);
        c.target = 11'h200;
        issue(c);
        // nine calls: the ninth lands on a full stack
        for (int k = 0; k < 9; k++) begin
            c.op = op_call;
            c.target = 11'h300 + 11'(k * 4);
            issue(c);
            chk(pc, 12'h300 + 12'(k * 4));
            chk(sp, 12'((k + 1) % 8));
        end
        issue(mk(op_ret, 7'h00, 4'h0));
        chk(pc, 12'h31d);
        issue(mk(op_ret, 7'h00, 4'h0));
        chk(pc, 12'h319);
        chk(sp, 12'h7);
        // call and return on consecutive edges, pushing at entry 7
        c.op = op_call;
        c.target = 11'h3f0;
        c.valid = 1'b1;
        @(posedge clk);
        #1;
        cmd = c;
        issue(mk(op_ret, 7'h00, 4'h0));
        chk(pc, 12'h31a);
        chk(sp, 12'h7);
        $display("test stack done");
    endtask

    task automatic t_index;
        cdm_cmd_t c;
        poke(7'h20, 4'h5);
        poke(7'h21, 4'ha);
        issue(mk(load_index_low_op, 7'h20, 4'h0));
        chk(ip, 12'h005);
        issue(mk(op_ldi, 7'h00, 4'h3));
        issue(mk(load_index_high_op, 7'h21, 4'h0));
        chk(ip, 12'h3a5);
        issue(mk(op_tbl_byte, 7'h00, 4'h0));
        chk(tout, 12'h063);
        c = mk(op_tbl_nib, 7'h00, 4'h0);
        c.nib_hi = 1'b1;
        issue(c);
        chk(tout, 12'h006);
        c.nib_hi = 1'b0;
        issue(c);
        chk(tout, 12'h003);
        // index 1a5h lies past the RAM and must read zero
        c = mk(op_ldr, 7'h00, 4'h0);
        c.amode = am_index;
        issue(c);
        chk(rd, 12'h0);
        // repoint at 021h, which holds a
        poke(7'h22, 4'h2);
        poke(7'h23, 4'h1);
        issue(mk(load_index_low_op, 7'h23, 4'h0));
        issue(mk(op_ldi, 7'h00, 4'h0));
        issue(mk(load_index_high_op, 7'h22, 4'h0));
        issue(c);
        chk(rd, 12'h00a);
        $display("test index done");
    endtask

    task automatic t_ram;
        logic [6:0] ad [5];
        logic [3:0] ex [5];
        cdm_cmd_t   c;
        ad = '{7'h4f, 7'h50, 7'h6f, 7'h70, 7'h7f};
        ex = '{4'h7, 4'h0, 4'h0, 4'hb, 4'hd};
        // hole cells get nonzero writes that must vanish
        for (int i = 0; i < 5; i++) begin
            poke(ad[i], ex[i] | {1'b0, i == 1 || i == 2, 2'h1});
        end
        for (int i = 0; i < 5; i++) begin
            issue(mk(op_ldr, ad[i], 4'h0));
            chk(rd, {8'h0, ex[i]});
        end
        c = mk(op_ldr, 7'h00, 4'h0);
        c.amode = am_work;
        c.wreg = 4'hf;
        issue(c);
        chk(acc, 12'h00d);
        c = mk(op_mwr, 7'h30, 4'h0);
        issue(c);
        issue(mk(op_ldr, 7'h30, 4'h0));
        chk(acc, 12'h00b);
        c = mk(op_mrw, 7'h30, 4'h0);
        c.wreg = 4'h3;
        issue(c);
        issue(mk(op_ldr, 7'h73, 4'h0));
        chk(acc, 12'h00b);
        c = mk(op_add, 7'h00, 4'h1);
        c.amode = am_work;
        c.store = 1'b1;
        issue(c);
        issue(mk(op_ldr, 7'h70, 4'h0));
        chk(acc, 12'h00c);
        $display("test ram done");
    endtask

    task automatic t_alu;
        cdm_op_t    ops [13];
        logic [3:0] im [13];
        logic [4:0] ex [13];
        cdm_cmd_t   c;
        ops = '{op_sub, op_sub, op_add, op_and, op_eor, op_or, op_inc,
                op_dec, op_adc, op_sbc, op_sr0, op_sl1, op_sub};
        im = '{4'h3, 4'h7, 4'hc, 4'h6, 4'h6, 4'ha, 4'h0, 4'h0, 4'h2, 4'h3,
               4'h0, 4'h0, 4'h5};
        ex = '{5'h12, 5'h0e, 5'h11, 5'h14, 5'h13, 5'h1f, 5'h06, 5'h14,
               5'h08, 5'h11, 5'h12, 5'h1b, 5'h10};
        poke(7'h10, 4'h5);
        // operand 5 against each immediate; expected {carry, acc}
        for (int i = 0; i < 13; i++) begin
            issue(mk(ops[i], 7'h10, im[i]));
            chk({cy, acc}, {7'h0, ex[i]});
            chk(zf, {11'h0, ex[i][3:0] == 4'h0});
        end
        c = mk(op_jz, 7'h00, 4'h0);
        c.target = 11'h155;
        issue(c);
        chk(pc, 12'h155);
        c.op = op_jnc;
        issue(c);
        chk(pc, 12'h156);
        c.op = op_jb;
        c.bsel = 2'h2;
        issue(c);
        chk(pc, 12'h157);
        c.op = op_jc;
        issue(c);
        chk(pc, 12'h155);
        c.op = op_jnz;
        issue(c);
        chk(pc, 12'h156);
        c.op = op_nop;
        issue(c);
        chk(pc, 12'h157);
        $display("test alu done");
    endtask

    task automatic t_decimal;
        logic [4:0] e;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 32; k++) begin
                // subtract from empty cell 01h to set or clear carry
                issue(mk(op_sub, 7'h01, {3'h0, ~k[4]}));
                issue(mk(op_ldi, 7'h00, k[3:0]));
                issue(mk(s ? decimal_adjust_sub_op : decimal_adjust_add_op,
                         7'h00, 4'h0));
                e = k[4:0];
                if (s == 0 && !k[4] && k[3:0] > 9) begin
                    e = {1'b1, k[3:0] + 4'h6};
                end
                if (s == 0 && k[4] && k[3:0] < 4) begin
                    e = {1'b1, k[3:0] + 4'h6};
                end
                if (s == 1 && !k[4] && k[3:0] > 5) begin
                    e = {1'b0, k[3:0] + 4'ha};
                end
                chk({cy, acc}, {7'h0, e});
            end
        end
        $display("test decimal done");
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        t_reset;
        t_vectors;
        t_stack;
        t_index;
        t_ram;
        t_alu;
        t_decimal;
        print_verdict;
    end

    // cut a hung run short
    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
endmodule
